// >>> common/cic_consts.svh
// constants of the cascaded interrupt controller
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH

// register map, 8-bit i/o addresses
`define MASTER_CMD_ADDR 8'h30
`define MASTER_MASK_ADDR 8'h32
`define SLAVE_CMD_ADDR 8'h40
`define SLAVE_MASK_ADDR 8'h42

// reset value: every level masked, user and expansion lines included
`define MASK_RESET 8'hff
`define ISR_RESET 8'h00
`define END_OF_SERVICE_CMD 8'h20

// vector = {base, level}; slots 0x40.. master, 0x48.. slave (user 0x4e, expansion 0x4d)
`define MASTER_VEC_BASE 5'h08
`define SLAVE_VEC_BASE 5'h09
`define CASCADE_LEVEL 3'h7
`define IDLE_LEVEL 3'h7
`define VECTOR_RESET 8'h00

// access timeout
`define TIMEOUT_NS 130000
`define CLK_PERIOD_NS 40
`define TMO_W 12
`define TIMEOUT_CYCLES (`TIMEOUT_NS / `CLK_PERIOD_NS)
`define TMO_LAST (`TMO_W'(`TIMEOUT_CYCLES - 1))
`define TMO_ZERO 12'h000
`define TMO_ONE 12'h001

`endif

// >>> common/cic_pkg.sv
// types shared by the cascaded interrupt controller
package cic_pkg;
  `include "cic_consts.svh"

  typedef enum logic [2:0] {
    ACK_IDLE = 3'b001,
    ACK_FIRST = 3'b010,
    ACK_SECOND = 3'b100
  } ack_state_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } io_bus_type;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] isr;
    logic intReq;
  } unit_state_type;

  typedef struct packed {
    ack_state_type ack;
    logic intaPrev;
    logic [7:0] vector;
    logic [7:0] dataOut;
    logic dataOe_n;
    logic cpuIrq;
    logic [`TMO_W-1:0] tmoCount;
    logic forceReady;
    logic nmi;
  } top_state_type;
endpackage

// >>> design/interrupt_priority_unit.sv
// one priority unit: mask, in-service bits, fully nested resolver
`timescale 1ns/100ps
`include "cic_consts.svh"
module interrupt_priority_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request levels, high = pending
  input wire logic [7:0] reqLevel,
  // register writes and acknowledge
  input wire logic maskWr,
  input wire logic cmdWr,
  input wire logic [7:0] wrData,
  input wire logic ackFirst,
  // state
  output logic intReq,
  output logic [7:0] maskValue,
  output logic [7:0] inService,
  output logic [2:0] bestLevel
);
  import cic_pkg::*;

  unit_state_type st;
  unit_state_type next_st;
  logic [7:0] eligible;

  // index of the lowest set bit, level 0 is the highest priority
  function automatic logic [2:0] lowestSet(input logic [7:0] v);
    logic [2:0] idx;
    idx = `IDLE_LEVEL;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  assign eligible = reqLevel & ~st.mask; // [R1] [R2]
  assign bestLevel = lowestSet(eligible);
  assign intReq = st.intReq;
  assign maskValue = st.mask;
  assign inService = st.isr;

  always_comb begin
    next_st = st;
    if (maskWr) begin
      next_st.mask = wrData;
    end
    // only an explicit end-of-service command retires a level
    if (cmdWr && wrData == `END_OF_SERVICE_CMD && |st.isr) begin
      next_st.isr[lowestSet(st.isr)] = 1'b0; // [R7]
    end
    if (ackFirst && |eligible) begin
      next_st.isr[bestLevel] = 1'b1;
    end
    // fully nested: only a level above everything in service gets through
    next_st.intReq = |eligible &&
      (next_st.isr == `ISR_RESET || bestLevel < lowestSet(next_st.isr)); // [R2] [R7]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mask: `MASK_RESET, isr: `ISR_RESET, intReq: 1'b0}; // [R12] [R13]
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_MASKED_SILENT: assert property ( // [R2]
    (reqLevel & ~st.mask) == `ISR_RESET |=> !intReq)
    else $error("request raised with no unmasked level pending");

  AST_LEVEL_HELD: assert property ( // [R1]
    (st.isr == `ISR_RESET && !ackFirst && (reqLevel & ~st.mask) != `ISR_RESET)
      |=> intReq)
    else $error("held level request not raised");
endmodule

// >>> design/cascaded_interrupt_controller.sv
// system interrupt circuit: cascaded master and slave units, acknowledge, timeout
// ============================================================================
// Notes on behaviour
// R1: a high level on a request input is pending; no edge detection.
// R2: request reaches the processor only if unmasked and above the in-service level.
// R3: on the first acknowledge pulse the data bus stays floating.
// R4: on the second acknowledge pulse the 8-bit vector of the grant is driven.
// R5: access without ready past the timeout gets forced ready plus a non-maskable interrupt.
// R6: a reinitialisation request goes out as a non-maskable interrupt, not a reset.
// R7: units work level-triggered, vectored, normal end of service, fully nested.
// R8: a requester holds its level until acknowledged, clears it by command or port.
// R9: a port-held request is dropped by the handler at its start.
// R10: handlers sit in four-byte slots from 100H; user slot 14, expansion 13.
// R11: master mask at 32H, slave mask at 42H, both readable and writable.
// R12: user line masked after reset; software clears slave mask bit 6.
// R13: expansion line masked after reset; software clears slave mask bit 5.
// R14: handler ends with end-of-service 20H to 40H, then to 30H.
// R15: expansion line is active low at the slot and inverted for the unit.
// R16: devices on the expansion line expose request status for polling.
// R17: only the user line is open to user boards; other slot lines are system.
// R18: slave output feeds one master input; only the master drives the processor.
`timescale 1ns/100ps
`include "cic_consts.svh"
module cascaded_interrupt_controller (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request lines
  input wire logic [6:0] masterIrq,
  input wire logic [5:0] slaveIrq,
  input wire logic userIrqLine,
  input wire logic expansionIrqLine_n,
  // i/o register access
  input wire cic_pkg::io_bus_type ioBus,
  // processor interrupt side
  input wire logic intAck_n,
  output logic cpuIrqIn,
  output logic [7:0] dataOut,
  output logic dataOe_n,
  // timeout monitor and reinitialisation
  input wire logic accessActive,
  input wire logic readyIn,
  input wire logic reinitReq,
  output logic forceReady,
  output logic nmiOut
);
  import cic_pkg::*;

  top_state_type st;
  top_state_type next_st;
  logic [7:0] masterReq;
  logic [7:0] slaveReq;
  logic masterInt;
  logic slaveInt;
  logic [7:0] masterMask;
  logic [7:0] slaveMask;
  logic [7:0] masterIsr;
  logic [7:0] slaveIsr;
  logic [2:0] masterBest;
  logic [2:0] slaveBest;
  logic intaFall;
  logic ackFirst;
  logic slaveAck;
  logic masterMaskWr;
  logic slaveMaskWr;
  logic masterCmdWr;
  logic slaveCmdWr;
  logic tmoFire;

  // ==========================================================================
  // request routing
  // slave levels: 0-4 system, 5 expansion, 6 user, 7 system
  assign slaveReq = {slaveIrq[5], userIrqLine, ~expansionIrqLine_n, slaveIrq[4:0]}; // [R15] [R17]
  // slave output occupies master level 7, the lowest priority
  assign masterReq = {slaveInt, masterIrq}; // [R18]

  // ==========================================================================
  // register decode
  assign masterMaskWr = ioBus.wr && ioBus.addr == `MASTER_MASK_ADDR; // [R11]
  assign slaveMaskWr = ioBus.wr && ioBus.addr == `SLAVE_MASK_ADDR; // [R11]
  assign masterCmdWr = ioBus.wr && ioBus.addr == `MASTER_CMD_ADDR;
  assign slaveCmdWr = ioBus.wr && ioBus.addr == `SLAVE_CMD_ADDR;

  assign intaFall = st.intaPrev && !intAck_n;
  assign ackFirst = st.ack == ACK_IDLE && intaFall;
  assign slaveAck = ackFirst && masterBest == `CASCADE_LEVEL; // [R18]

  interrupt_priority_unit masterUnit (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reqLevel(masterReq),
    .maskWr(masterMaskWr),
    .cmdWr(masterCmdWr),
    .wrData(ioBus.data),
    .ackFirst(ackFirst),
    .intReq(masterInt),
    .maskValue(masterMask),
    .inService(masterIsr),
    .bestLevel(masterBest)
  );

  interrupt_priority_unit slaveUnit (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reqLevel(slaveReq),
    .maskWr(slaveMaskWr),
    .cmdWr(slaveCmdWr),
    .wrData(ioBus.data),
    .ackFirst(slaveAck),
    .intReq(slaveInt),
    .maskValue(slaveMask),
    .inService(slaveIsr),
    .bestLevel(slaveBest)
  );

  // ==========================================================================
  // timeout monitor
  assign tmoFire = accessActive && !readyIn && !st.forceReady && st.tmoCount == `TMO_LAST;

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.intaPrev = intAck_n;
    next_st.cpuIrq = masterInt; // [R18]
    unique case (st.ack)
      ACK_IDLE: begin
        if (intaFall) begin
          next_st.ack = ACK_FIRST;
          // vector is frozen on the first pulse
          if (masterBest == `CASCADE_LEVEL) begin
            next_st.vector = {`SLAVE_VEC_BASE, slaveBest};
          end else begin
            next_st.vector = {`MASTER_VEC_BASE, masterBest};
          end
        end
      end
      ACK_FIRST: begin
        if (intaFall) begin
          next_st.ack = ACK_SECOND;
        end
      end
      ACK_SECOND: begin
        if (intAck_n) begin
          next_st.ack = ACK_IDLE;
        end
      end
    endcase
    // data bus: vector, then mask reads, otherwise released
    next_st.dataOe_n = 1'b1;
    next_st.dataOut = `VECTOR_RESET;
    if (next_st.ack == ACK_SECOND) begin
      next_st.dataOe_n = 1'b0; // [R4]
      next_st.dataOut = next_st.vector; // [R4]
    end else if (next_st.ack == ACK_FIRST) begin
      next_st.dataOe_n = 1'b1; // [R3]
    end else if (ioBus.rd && ioBus.addr == `MASTER_MASK_ADDR) begin
      next_st.dataOe_n = 1'b0; // [R11]
      next_st.dataOut = masterMask;
    end else if (ioBus.rd && ioBus.addr == `SLAVE_MASK_ADDR) begin
      next_st.dataOe_n = 1'b0; // [R11]
      next_st.dataOut = slaveMask;
    end
    // stalled access counter; forced ready holds until the access ends
    if (!accessActive) begin
      next_st.tmoCount = `TMO_ZERO;
      next_st.forceReady = 1'b0;
    end else if (readyIn || st.forceReady) begin
      next_st.tmoCount = `TMO_ZERO;
    end else if (tmoFire) begin
      next_st.tmoCount = `TMO_ZERO;
      next_st.forceReady = 1'b1; // [R5]
    end else begin
      next_st.tmoCount = st.tmoCount + `TMO_ONE;
    end
    next_st.nmi = tmoFire || reinitReq; // [R5] [R6]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ack: ACK_IDLE, intaPrev: 1'b1, vector: `VECTOR_RESET,
              dataOut: `VECTOR_RESET, dataOe_n: 1'b1, cpuIrq: 1'b0,
              tmoCount: `TMO_ZERO, forceReady: 1'b0, nmi: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign cpuIrqIn = st.cpuIrq;
  assign dataOut = st.dataOut;
  assign dataOe_n = st.dataOe_n;
  assign forceReady = st.forceReady;
  assign nmiOut = st.nmi;

  // ==========================================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence firstPulse;
    st.ack == ACK_IDLE && intaFall;
  endsequence

  sequence secondPulse;
    st.ack == ACK_FIRST && intaFall;
  endsequence

  sequence stalledToLimit;
    accessActive && !readyIn && !st.forceReady && st.tmoCount == `TMO_LAST;
  endsequence

  AST_MASKED_MASTER: assert property ( // [R2]
    masterMask == `MASK_RESET |=> ##1 !cpuIrqIn)
    else $error("processor interrupt raised with all master levels masked");

  AST_FIRST_FLOATS: assert property ( // [R3]
    firstPulse |=> dataOe_n)
    else $error("data bus driven on first acknowledge");

  AST_SECOND_VECTOR: assert property ( // [R4]
    secondPulse |=> !dataOe_n && dataOut == st.vector && st.vector == $past(st.vector))
    else $error("vector not driven on second acknowledge");

  AST_TIMEOUT_NMI: assert property ( // [R5]
    stalledToLimit |=> forceReady && nmiOut ##1 (forceReady || !accessActive))
    else $error("timeout did not force ready and raise nmi together");

  AST_REINIT_NMI: assert property ( // [R6]
    reinitReq |=> nmiOut)
    else $error("reinitialisation request not sent as nmi");

  AST_NORMAL_EOI: assert property ( // [R7]
    $fell(|masterIsr) |-> $past(masterCmdWr) && $past(ioBus.data) == `END_OF_SERVICE_CMD)
    else $error("master in-service cleared without end-of-service command");

  AST_MASK_READBACK: assert property ( // [R11]
    slaveMaskWr ##1 !slaveMaskWr
      ##1 (ioBus.rd && ioBus.addr == `SLAVE_MASK_ADDR && !ioBus.wr
      && st.ack == ACK_IDLE && !intaFall)
      |=> !dataOe_n && dataOut == $past(ioBus.data, 3))
    else $error("slave mask does not read back the written value");

  AST_USER_MASKED: assert property ( // [R12]
    slaveMask[6] && !slaveMaskWr |=> slaveMask[6])
    else $error("user line unmasked without a mask write");

  AST_EXP_MASKED: assert property ( // [R13]
    slaveMask[5] && !slaveMaskWr |=> slaveMask[5])
    else $error("expansion line unmasked without a mask write");

  AST_EXP_INVERT: assert property ( // [R15]
    slaveReq[5] == !expansionIrqLine_n)
    else $error("expansion line not inverted into the slave");

  AST_CASCADE_PATH: assert property ( // [R18]
    slaveInt && !masterMask[7] && masterIsr == `ISR_RESET && st.ack == ACK_IDLE
      && !intaFall |-> ##[1:3] cpuIrqIn)
    else $error("slave request did not reach the processor through the master");
endmodule

// >>> tb/host_cpu_model.sv
// processor and bus controller model: i/o cycles and the two-pulse acknowledge
`timescale 1ns/100ps
`include "cic_consts.svh"
module host_cpu_model (
  // clock
  input wire logic clk_sys,
  // bus towards the controller
  output cic_pkg::io_bus_type ioBus,
  output logic intAck_n,
  // data bus from the controller
  input wire logic [7:0] dataOut,
  input wire logic dataOe_n
);
  import cic_pkg::*;
  initial begin
    ioBus = '0;
    intAck_n = 1'b1;
  end
  // ==========================================================================
  // i/o cycles
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1 ioBus = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    @(posedge clk_sys) #1 ioBus.wr = 1'b0;
  endtask
  task automatic io_read(input logic [7:0] a, output logic [7:0] d, output logic oe_n);
    @(posedge clk_sys) #1 ioBus = '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    repeat (2) @(posedge clk_sys);
    #1 d = dataOut;
    oe_n = dataOe_n;
    ioBus.rd = 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // read, and with the value, write back: clears one slave mask bit
  task automatic unmask_slave(input logic [7:0] andValue);
    logic [7:0] d;
    logic oe_n;
    io_read(`SLAVE_MASK_ADDR, d, oe_n);
    io_write(`SLAVE_MASK_ADDR, d & andValue);
  endtask
  task automatic end_of_service();
    io_write(`SLAVE_CMD_ADDR, `END_OF_SERVICE_CMD);
    io_write(`MASTER_CMD_ADDR, `END_OF_SERVICE_CMD);
  endtask
  // ==========================================================================
  // acknowledge: two low pulses, high between them
  task automatic ack_cycle(output logic [7:0] vec, output logic oe1_n, output logic oe2_n);
    @(posedge clk_sys) #1 intAck_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 oe1_n = dataOe_n;
    intAck_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 intAck_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 vec = dataOut;
    oe2_n = dataOe_n;
    intAck_n = 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

// >>> tb/cascaded_interrupt_controller_test.sv
// self-checking testbench of the cascaded interrupt controller
`timescale 1ns/100ps
`include "cic_consts.svh"
module cascaded_interrupt_controller_test;
  import cic_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] masterIrq = '0;
  logic [5:0] slaveIrq = '0;
  logic userIrqLine = 1'b0;
  logic expansionIrqLine_n = 1'b1;
  io_bus_type ioBus;
  logic intAck_n, cpuIrqIn, dataOe_n, forceReady, nmiOut;
  logic [7:0] dataOut;
  logic accessActive = 1'b0;
  logic readyIn = 1'b0;
  logic reinitReq = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  always #20 clk_sys = ~clk_sys;
  cascaded_interrupt_controller dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .masterIrq(masterIrq), .slaveIrq(slaveIrq), .userIrqLine(userIrqLine),
    .expansionIrqLine_n(expansionIrqLine_n), .ioBus(ioBus), .intAck_n(intAck_n),
    .cpuIrqIn(cpuIrqIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .accessActive(accessActive), .readyIn(readyIn), .reinitReq(reinitReq),
    .forceReady(forceReady), .nmiOut(nmiOut));
  host_cpu_model host_u (.clk_sys(clk_sys), .ioBus(ioBus), .intAck_n(intAck_n),
    .dataOut(dataOut), .dataOe_n(dataOe_n));
  // ==========================================================================
  // compares and waits
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_high(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic idle_irq(input logic exp);
    repeat (8) @(posedge clk_sys);
    #1 check_bit("cpuIrqIn", exp, cpuIrqIn);
  endtask
  task automatic acknowledge(input logic [7:0] expVec);
    logic [7:0] v;
    logic oe1, oe2;
    host_u.ack_cycle(v, oe1, oe2);
    check_bit("dataOe_n first pulse", 1'b1, oe1);
    check_bit("dataOe_n second pulse", 1'b0, oe2);
    check_byte("vector", expVec, v);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_registers();
    logic [7:0] d;
    logic oe;
    host_u.io_read(`MASTER_MASK_ADDR, d, oe);
    check_byte("master mask", 8'hff, d);
    host_u.io_read(`SLAVE_MASK_ADDR, d, oe);
    check_byte("slave mask", 8'hff, d);
    host_u.io_write(`SLAVE_MASK_ADDR, 8'hfe);
    host_u.io_read(`SLAVE_MASK_ADDR, d, oe);
    check_byte("slave mask", 8'hfe, d);
    host_u.io_write(`MASTER_MASK_ADDR, 8'h5a);
    host_u.io_read(`MASTER_MASK_ADDR, d, oe);
    check_byte("master mask", 8'h5a, d);
    host_u.io_read(`MASTER_CMD_ADDR, d, oe);
    check_bit("dataOe_n command read", 1'b1, oe);
    host_u.io_write(`MASTER_MASK_ADDR, 8'h7f);
    @(posedge clk_sys) #1 userIrqLine = 1'b1;
    idle_irq(1'b0);
  endtask
  task automatic t_user_nested();
    logic [7:0] d;
    logic oe;
    int n;
    host_u.unmask_slave(8'hbf);
    wait_high(cpuIrqIn, 8, n);
    check_bit("cpuIrqIn user", 1'b1, cpuIrqIn);
    acknowledge(8'h40 + 8'd14);
    idle_irq(1'b0);
    host_u.unmask_slave(8'hdf);
    @(posedge clk_sys) #1 expansionIrqLine_n = 1'b0;
    idle_irq(1'b0);
    host_u.io_write(`MASTER_MASK_ADDR, 8'h7e);
    @(posedge clk_sys) #1 masterIrq[0] = 1'b1;
    wait_high(cpuIrqIn, 8, n);
    check_bit("cpuIrqIn master 0", 1'b1, cpuIrqIn);
    acknowledge(8'h40);
    @(posedge clk_sys) #1 masterIrq[0] = 1'b0;
    userIrqLine = 1'b0;
    host_u.end_of_service();
    host_u.end_of_service();
    wait_high(cpuIrqIn, 8, n);
    check_bit("cpuIrqIn expansion", 1'b1, cpuIrqIn);
    acknowledge(8'h40 + 8'd13);
    // handler has polled the requester and clears it at its port
    @(posedge clk_sys) #1 expansionIrqLine_n = 1'b1;
    host_u.end_of_service();
    idle_irq(1'b0);
    host_u.io_read(`SLAVE_MASK_ADDR, d, oe);
    check_byte("slave mask", 8'h9e, d);
  endtask
  task automatic t_timeout();
    int n;
    @(posedge clk_sys) #1 accessActive = 1'b1;
    repeat (2000) @(posedge clk_sys);
    #1 readyIn = 1'b1;
    @(posedge clk_sys) #1 readyIn = 1'b0;
    repeat (2000) @(posedge clk_sys);
    #1 check_bit("forceReady early", 1'b0, forceReady);
    wait_high(forceReady, 1300, n);
    check_bit("timeout span", 1'b1, n >= 1248 && n <= 1252);
    check_bit("nmiOut with forceReady", 1'b1, nmiOut);
    @(posedge clk_sys) #1 check_bit("nmiOut pulse", 1'b0, nmiOut);
    accessActive = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check_bit("forceReady released", 1'b0, forceReady);
  endtask
  task automatic t_reinit();
    int n;
    @(posedge clk_sys) #1 reinitReq = 1'b1;
    @(posedge clk_sys) #1 reinitReq = 1'b0;
    wait_high(nmiOut, 3, n);
    check_bit("nmiOut reinit", 1'b1, nmiOut);
    @(posedge clk_sys) #1 check_bit("nmiOut reinit end", 1'b0, nmiOut);
  endtask
  // ==========================================================================
  // verdict and sequence
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_registers();
    t_user_nested();
    t_timeout();
    t_reinit();
    end_of_test();
  end
endmodule
